// File: rtl/usart_ctrl_pkg.sv
/*
 * Constants for the serial unit's mode, baud and flag logic:
 * register indices, field positions, reset values.
 * Assumes a 32-bit APB with word-aligned registers (byte address = 4 * index).
 */
`default_nettype none

package usart_ctrl_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [9:0] IDX_DATA_BUF   = 10'h0C1;
	localparam logic [9:0] IDX_BAUD_MANT  = 10'h0C2;
	localparam logic [9:0] IDX_CTRL_STAT  = 10'h0C4;
	localparam logic [9:0] IDX_BAUD_EXP   = 10'h0C5;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h0C8;
	localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h0C9;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0CA;

	// Control/status field positions
	localparam int BIT_MODE   = 7;
	localparam int BIT_RX_ON  = 6;
	localparam int BIT_SLAVE  = 5;
	localparam int BIT_FRAME  = 4;
	localparam int BIT_PARITY = 3;
	localparam int BIT_RXBYTE = 2;
	localparam int BIT_TXBYTE = 1;
	localparam int BIT_ACTIVE = 0;

	// Interrupt status bit positions
	localparam int IRQ_FRAME  = 0;
	localparam int IRQ_PARITY = 1;
	localparam int IRQ_RXBYTE = 2;
	localparam int IRQ_TXBYTE = 3;

	// Reset values
	localparam logic [7:0]  RST_BAUD_MANT = 8'h00;
	localparam logic [4:0]  RST_BAUD_EXP  = 5'h00;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [3:0]  RST_IRQ       = 4'h0;
	localparam logic [27:0] RST_PHASE     = 28'h0000000;

	// Baud phase accumulator: rate = clk * (256 + M) * 2^E / 2^28
	localparam int          PHASE_BITS    = 28;
	localparam logic [8:0]  MANT_OFFSET   = 9'h100;

endpackage

`default_nettype wire

// File: rtl/usart_ctrl.sv
/*
 * Mode select, baud generator and control/status flags of a dual-mode
 * UART / SPI serial unit, with an APB register slave and one interrupt.
 * Assumes a shift engine on the same MCLK that reports events as
 * one-cycle pulses and a busy level, and a slave-select pin from outside.
 */
// Added by the designer: the APB interface to the registers.
`default_nettype none

// Summary of operation
// - Eight-bit read/write baud mantissa, reset zero, sets bit rate with exponent.
// - Control bit 7 picks mode: 0 SPI, 1 UART; reset gives SPI.
// - Control bit 6 enables UART reception; reset leaves receiver off.
// - Control bit 5 picks SPI role: 0 master, 1 slave; reset master.
// - Bit 4 set when a UART byte has a wrong stop level.
// - Any read of control/status clears the framing flag.
// - Bit 3 set when a received UART byte fails parity.
// - Any read of control/status clears the parity flag.
// - Bit 2 set on a complete received byte in UART or SPI slave.
// - Reading the data buffer clears the received-byte flag.
// - Writing 0 to bit 2 clears it and discards the received byte.
// - Bit 1 set when the last written byte is sent, UART or master.
// - Read-only bit 0 shows busy transmitting or receiving.
// - In SPI slave mode bit 0 follows the slave-select level.
// - Five-bit baud exponent, reset zero, combines with the mantissa.
// - Data buffer writes load transmit holding; reads return receive holding.
module usart_ctrl
	import usart_ctrl_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RX_DONE,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_FRAME_BAD,
	input  wire logic        RX_PARITY_BAD,
	input  wire logic        TX_DONE,
	input  wire logic        ENGINE_BUSY,
	input  wire logic        SSN_N,
	output logic             MODE_UART,
	output logic             RX_ON,
	output logic             SPI_SLAVE,
	output logic             BAUD_TICK,
	output logic      [7:0]  TX_DATA,
	output logic             TX_LOAD,
	output logic             IRQ
);

	typedef struct packed {
		logic [7:0]  baud_mant;
		logic [4:0]  baud_exp;
		logic        mode_uart;
		logic        rx_on;
		logic        slave;
		logic        frame_flag;
		logic        parity_flag;
		logic        rx_flag;
		logic        tx_flag;
		logic [7:0]  rx_buf;
		logic [7:0]  tx_buf;
		logic        tx_load;
		logic        tick;
		logic [27:0] phase;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_en;
		logic        ssn_meta;
		logic        ssn_sync;
	} state_s;

	state_s q;
	state_s d;

	// Word hit on the APB address; misaligned addresses never hit
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
	endfunction

	logic        acc_rd;
	logic        acc_wr;
	logic        mapped;
	logic        rd_csr;
	logic        rd_data;
	logic        wr_csr;
	logic        wr_data;
	logic        rx_take;
	logic        frame_ev;
	logic        parity_ev;
	logic        tx_ev;
	logic        active;
	logic [40:0] phase_sum;
	logic [39:0] phase_inc;
	logic [7:0]  csr_view;

	// Access phase of an APB transfer; no wait states
	assign acc_rd  = PSEL && PENABLE && !PWRITE;
	assign acc_wr  = PSEL && PENABLE && PWRITE;
	assign mapped  = hit(PADDR, IDX_DATA_BUF) || hit(PADDR, IDX_BAUD_MANT) || hit(PADDR, IDX_CTRL_STAT)
		|| hit(PADDR, IDX_BAUD_EXP) || hit(PADDR, IDX_IRQ_STATUS) || hit(PADDR, IDX_IRQ_CLEAR)
		|| hit(PADDR, IDX_IRQ_ENABLE);
	assign rd_csr  = acc_rd && hit(PADDR, IDX_CTRL_STAT);
	assign rd_data = acc_rd && hit(PADDR, IDX_DATA_BUF);
	assign wr_csr  = acc_wr && hit(PADDR, IDX_CTRL_STAT);
	assign wr_data = acc_wr && hit(PADDR, IDX_DATA_BUF);

	// receiver gate
	// UART bytes are dropped while the receiver is off, so a half-configured
	// receiver cannot flag garbage
	assign rx_take = RX_DONE && (q.mode_uart ? q.rx_on : q.slave);
	assign frame_ev  = rx_take && q.mode_uart && RX_FRAME_BAD;
	assign parity_ev = rx_take && q.mode_uart && RX_PARITY_BAD;
	assign tx_ev     = TX_DONE && (q.mode_uart || !q.slave);

	assign active = (!q.mode_uart && q.slave) ? q.ssn_sync : ENGINE_BUSY;

	// phase step is (256 + M) shifted by E
	assign phase_inc = 40'({31'h0, MANT_OFFSET + {1'b0, q.baud_mant}} << q.baud_exp);
	assign phase_sum = {13'h0, q.phase} + {1'b0, phase_inc};

	assign csr_view = {q.mode_uart, q.rx_on, q.slave, q.frame_flag, q.parity_flag, q.rx_flag, q.tx_flag, active};

	// Next state
	always_comb begin
		d = q;
		d.tx_load  = 1'b0;
		d.ssn_meta = SSN_N;
		d.ssn_sync = q.ssn_meta;
		// baud accumulator
		// Any carry past 2^28 gives a tick; above the clock rate it ticks every cycle
		d.phase = phase_sum[27:0];
		d.tick  = (phase_sum[40:PHASE_BITS] != 13'h0);

		// Clears first, so a same-cycle event below wins
		// read clears errors
		if (rd_csr) begin
			d.frame_flag  = 1'b0;
			d.parity_flag = 1'b0;
		end
		if (rd_data) begin
			d.rx_flag = 1'b0;
		end
		if (acc_wr) begin
			if (hit(PADDR, IDX_BAUD_MANT)) begin
				d.baud_mant = PWDATA[7:0];
			end
			if (hit(PADDR, IDX_BAUD_EXP)) begin
				d.baud_exp = PWDATA[4:0];
			end
			if (wr_csr) begin
				d.mode_uart = PWDATA[BIT_MODE];
				d.rx_on     = PWDATA[BIT_RX_ON];
				d.slave     = PWDATA[BIT_SLAVE];
				if (!PWDATA[BIT_FRAME]) begin
					d.frame_flag = 1'b0;
				end
				if (!PWDATA[BIT_PARITY]) begin
					d.parity_flag = 1'b0;
				end
				if (!PWDATA[BIT_TXBYTE]) begin
					d.tx_flag = 1'b0;
				end
				if (!PWDATA[BIT_RXBYTE]) begin
					d.rx_flag = 1'b0;
					d.rx_buf  = RST_BYTE;
				end
			end
			if (wr_data) begin
				d.tx_buf  = PWDATA[7:0];
				d.tx_load = 1'b1;
			end
			if (hit(PADDR, IDX_IRQ_CLEAR)) begin
				d.irq_stat = q.irq_stat & ~PWDATA[3:0];
			end
			if (hit(PADDR, IDX_IRQ_ENABLE)) begin
				d.irq_en = PWDATA[3:0];
			end
		end

		// Hardware sets, winning over any clear in the same cycle
		// framing set
		if (frame_ev) begin
			d.frame_flag = 1'b1;
			d.irq_stat[IRQ_FRAME] = 1'b1;
		end
		if (parity_ev) begin
			d.parity_flag = 1'b1;
			d.irq_stat[IRQ_PARITY] = 1'b1;
		end
		if (rx_take) begin
			d.rx_flag = 1'b1;
			d.rx_buf  = RX_DATA;
			d.irq_stat[IRQ_RXBYTE] = 1'b1;
		end
		if (tx_ev) begin
			d.tx_flag = 1'b1;
			d.irq_stat[IRQ_TXBYTE] = 1'b1;
		end
	end

	// State register
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			q.baud_mant   <= RST_BAUD_MANT;
			q.baud_exp    <= RST_BAUD_EXP;
			q.mode_uart   <= 1'b0;
			q.rx_on       <= 1'b0;
			q.slave       <= 1'b0;
			q.frame_flag  <= 1'b0;
			q.parity_flag <= 1'b0;
			q.rx_flag     <= 1'b0;
			q.tx_flag     <= 1'b0;
			q.rx_buf      <= RST_BYTE;
			q.tx_buf      <= RST_BYTE;
			q.tx_load     <= 1'b0;
			q.tick        <= 1'b0;
			q.phase       <= RST_PHASE;
			q.irq_stat    <= RST_IRQ;
			q.irq_en      <= RST_IRQ;
			q.ssn_meta    <= 1'b1;
			q.ssn_sync    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Read mux; unused upper bits read zero
	always_comb begin
		PRDATA = 32'h00000000;
		if (acc_rd) begin
			if (hit(PADDR, IDX_DATA_BUF)) begin
				PRDATA = {24'h000000, q.rx_buf};
			end else if (hit(PADDR, IDX_BAUD_MANT)) begin
				PRDATA = {24'h000000, q.baud_mant};
			end else if (hit(PADDR, IDX_CTRL_STAT)) begin
				PRDATA = {24'h000000, csr_view};
			end else if (hit(PADDR, IDX_BAUD_EXP)) begin
				PRDATA = {27'h0, q.baud_exp};
			end else if (hit(PADDR, IDX_IRQ_STATUS)) begin
				PRDATA = {28'h0000000, q.irq_stat};
			end else if (hit(PADDR, IDX_IRQ_ENABLE)) begin
				PRDATA = {28'h0000000, q.irq_en};
			end
		end
	end

	// Outputs
	assign PREADY    = 1'b1;
	assign PSLVERR   = PSEL && PENABLE && !mapped;
	assign MODE_UART = q.mode_uart;
	assign RX_ON     = q.rx_on;
	assign SPI_SLAVE = q.slave;
	assign BAUD_TICK = q.tick;
	assign TX_DATA   = q.tx_buf;
	assign TX_LOAD   = q.tx_load;
	assign IRQ       = |(q.irq_stat & q.irq_en);

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence s_data_write;
		acc_wr && hit(PADDR, IDX_DATA_BUF);
	endsequence

	sequence s_load_pulse;
		TX_LOAD ##1 !TX_LOAD;
	endsequence

	// Load rises in the cycle right after the write edge and lasts one cycle
	a_tx_load_pulse: assert property (s_data_write ##1 !(acc_wr && hit(PADDR, IDX_DATA_BUF)) |-> s_load_pulse)
		else $error("data write did not give one load pulse");

	a_tx_data_hold: assert property (s_data_write |=> TX_DATA == $past(PWDATA[7:0]))
		else $error("transmit holding not loaded");

	a_rx_flag_set: assert property (rx_take |=> q.rx_flag && q.rx_buf == $past(RX_DATA))
		else $error("received byte not flagged");

	a_rx_gate_off: assert property (RX_DONE && q.mode_uart && !q.rx_on |=> $stable(q.rx_buf))
		else $error("byte taken with receiver off");

	a_frame_read_clr: assert property (rd_csr && !frame_ev |=> !q.frame_flag)
		else $error("framing flag survived status read");

	a_parity_set: assert property (parity_ev |=> q.parity_flag ##1 (q.parity_flag || $past(rd_csr) || $past(wr_csr)))
		else $error("parity flag not held");

	a_rx_discard: assert property (wr_csr && !PWDATA[BIT_RXBYTE] && !rx_take
		|=> !q.rx_flag && q.rx_buf == RST_BYTE)
		else $error("write zero did not discard byte");

	a_rx_read_clr: assert property (rd_data && !rx_take |=> !q.rx_flag)
		else $error("data read did not clear byte flag");

	a_tx_slave_quiet: assert property (TX_DONE && !q.mode_uart && q.slave && !q.tx_flag |=> !q.tx_flag)
		else $error("sent flag set in SPI slave");

	a_active_slave: assert property (!q.mode_uart && q.slave |-> csr_view[BIT_ACTIVE] == $past(SSN_N, 2))
		else $error("activity does not follow slave select");

	a_active_engine: assert property (q.mode_uart |-> csr_view[BIT_ACTIVE] == ENGINE_BUSY)
		else $error("activity does not follow engine");

	a_mode_write: assert property (wr_csr |=> MODE_UART == $past(PWDATA[BIT_MODE]) && SPI_SLAVE == $past(PWDATA[BIT_SLAVE])
		&& RX_ON == $past(PWDATA[BIT_RX_ON]))
		else $error("mode bits not written");

	a_fast_tick: assert property ((q.baud_exp > 5'd20) [*2] |-> BAUD_TICK)
		else $error("tick missing at top rate");

	a_mant_write: assert property (acc_wr && hit(PADDR, IDX_BAUD_MANT) |=> q.baud_mant == $past(PWDATA[7:0]))
		else $error("mantissa not written");

endmodule

`default_nettype wire

// File: dv/engine_model.sv
/* Behavioural shift engine and far peer: answers rx/tx commands after a lag.
 * Assumes commands arrive from the bench by non-blocking assignment at clk rise. */
`default_nettype none
module engine_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       go_rx,
	input  wire logic       go_tx,
	input  wire logic [7:0] rx_val,
	input  wire logic       fe,
	input  wire logic       pe,
	input  wire logic [3:0] lag,
	output logic            rx_done,
	output logic      [7:0] rx_data,
	output logic            frame_bad,
	output logic            parity_bad,
	output logic            tx_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic       arm_q, is_rx_q;

	// One pulse per event; data only valid with it, inverted otherwise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{arm_q, is_rx_q, rx_done, tx_done, frame_bad, parity_bad} <= '0;
			cnt_q <= '0;
			rx_data <= 8'h00;
		end else begin
			rx_done <= 1'b0;
			tx_done <= 1'b0;
			rx_data <= ~rx_data;
			frame_bad <= ~frame_bad;
			parity_bad <= ~parity_bad;
			if (go_rx || go_tx) begin
				arm_q <= 1'b1;
				is_rx_q <= go_rx;
				cnt_q <= lag;
			end else if (arm_q && cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
			end else if (arm_q) begin
				arm_q <= 1'b0;
				rx_done <= is_rx_q;
				tx_done <= !is_rx_q;
				rx_data <= rx_val;
				frame_bad <= fe;
				parity_bad <= pe;
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/testbench.sv
/* Self-checking bench for the serial unit's registers, flags, irq and baud tick.
 * Assumes engine_model stands in for the shift engine and the remote peer. */
`default_nettype none
module testbench;
	import usart_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        rx_done, frame_bad, parity_bad, tx_done, busy_in, ssel_in;
	logic [7:0]  rx_data, tx_data, rx_val;
	logic        mode_uart, rx_on, spi_slave, baud_tick, tx_load, irq;
	logic        go_rx, go_tx, fe, pe;
	logic [3:0]  lag;
	logic [7:0]  mt[3] = '{8'h00, 8'h80, 8'h00};
	logic [4:0]  et[3] = '{5'h13, 5'h13, 5'h14};
	int          nt[3] = '{10, 15, 20};
	int          err_total, num_checks;

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	usart_ctrl usart_ctrl_inst (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX_DONE(rx_done), .RX_DATA(rx_data), .RX_FRAME_BAD(frame_bad),
		.RX_PARITY_BAD(parity_bad), .TX_DONE(tx_done), .ENGINE_BUSY(busy_in), .SSN_N(ssel_in),
		.MODE_UART(mode_uart), .RX_ON(rx_on), .SPI_SLAVE(spi_slave), .BAUD_TICK(baud_tick),
		.TX_DATA(tx_data), .TX_LOAD(tx_load), .IRQ(irq));

	engine_model engine_model_inst (.clk(mclk), .rst_n(rst_n), .go_rx(go_rx), .go_tx(go_tx),
		.rx_val(rx_val), .fe(fe), .pe(pe), .lag(lag), .rx_done(rx_done), .rx_data(rx_data),
		.frame_bad(frame_bad), .parity_bad(parity_bad), .tx_done(tx_done));

	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask

	// One APB transfer; idle cycle before it so no signal is driven twice at one edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		// Answer taken at the rising edge where pready is seen high, then released
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			close_out;
		end
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, {i, 2'b00}, d, r, e);
	endtask

	task automatic rd(input logic [9:0] i, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, {i, 2'b00}, 32'h0, r, e);
		chk($sformatf("reg %h", i), x, r);
	endtask

	// Commands the engine: r=1 receive, r=0 transmit; waits until the flag has landed
	task automatic ev(input logic r, input logic [7:0] v, input logic f, input logic p, input logic [3:0] l);
		@(posedge mclk);
		go_rx <= r; go_tx <= !r; rx_val <= v; fe <= f; pe <= p; lag <= l;
		@(posedge mclk);
		go_rx <= 1'b0; go_tx <= 1'b0;
		repeat (l + 3) @(posedge mclk);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		close_out;
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic e;
		int n;
		{psel, penable, pwrite, go_rx, go_tx, fe, pe, busy_in} = '0;
		paddr = 12'h000; pwdata = 32'h0; rx_val = 8'h00; lag = 4'h0;
		ssel_in = 1'b1; rst_n = 1'b0; err_total = 0; num_checks = 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(IDX_BAUD_MANT, 32'h0);
		rd(IDX_CTRL_STAT, 32'h0);
		rd(IDX_BAUD_EXP, 32'h0);
		wr(IDX_BAUD_MANT, 32'hA5);
		rd(IDX_BAUD_MANT, 32'hA5);
		wr(IDX_BAUD_EXP, 32'hFF);
		rd(IDX_BAUD_EXP, 32'h1F);
		wr(IDX_CTRL_STAT, 32'hE0);
		@(negedge mclk);
		chk("modes", 3'b111, {mode_uart, rx_on, spi_slave});
		wr(IDX_IRQ_ENABLE, 32'hF);
		wr(IDX_CTRL_STAT, 32'h80);
		wr(IDX_CTRL_STAT, 32'hC0);
		ev(1'b1, 8'h5A, 1'b1, 1'b1, 4'h5);
		rd(IDX_CTRL_STAT, 32'hDC);
		rd(IDX_CTRL_STAT, 32'hC4);
		chk("irq", 1, irq);
		rd(IDX_IRQ_STATUS, 32'h7);
		rd(IDX_DATA_BUF, 32'h5A);
		rd(IDX_CTRL_STAT, 32'hC0);
		ev(1'b1, 8'hC3, 1'b0, 1'b0, 4'h0);
		wr(IDX_CTRL_STAT, 32'hC4);
		rd(IDX_CTRL_STAT, 32'hC4);
		wr(IDX_CTRL_STAT, 32'hC0);
		rd(IDX_CTRL_STAT, 32'hC0);
		rd(IDX_DATA_BUF, 32'h0);
		wr(IDX_CTRL_STAT, 32'h80);
		ev(1'b1, 8'h11, 1'b1, 1'b1, 4'h0);
		rd(IDX_CTRL_STAT, 32'h80);
		wr(IDX_DATA_BUF, 32'h3C);
		#1 chk("tx load", 9'h13C, {tx_load, tx_data});
		ev(1'b0, 8'h00, 1'b0, 1'b0, 4'h2);
		rd(IDX_CTRL_STAT, 32'h82);
		wr(IDX_CTRL_STAT, 32'h00);
		ev(1'b0, 8'h00, 1'b0, 1'b0, 4'h0);
		rd(IDX_CTRL_STAT, 32'h02);
		wr(IDX_CTRL_STAT, 32'h20);
		ev(1'b0, 8'h00, 1'b0, 1'b0, 4'h0);
		ev(1'b1, 8'h77, 1'b1, 1'b1, 4'h0);
		rd(IDX_CTRL_STAT, 32'h25);
		ssel_in <= 1'b0;
		rd(IDX_CTRL_STAT, 32'h24);
		busy_in <= 1'b1;
		wr(IDX_CTRL_STAT, 32'h80);
		rd(IDX_CTRL_STAT, 32'h81);
		busy_in <= 1'b0;
		rd(IDX_IRQ_STATUS, 32'hF);
		wr(IDX_IRQ_CLEAR, 32'hF);
		rd(IDX_IRQ_STATUS, 32'h0);
		chk("irq", 0, irq);
		wr(IDX_IRQ_ENABLE, 32'h8);
		wr(IDX_CTRL_STAT, 32'hC0);
		ev(1'b1, 8'h01, 1'b0, 1'b0, 4'h0);
		chk("irq", 0, irq);
		wr(IDX_IRQ_ENABLE, 32'h4);
		@(negedge mclk);
		chk("irq", 1, irq);
		apb(1'b0, 12'hFFC, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		// Bit rate table: ticks in 20 cycles
		for (int k = 0; k < 3; k++) begin
			wr(IDX_BAUD_MANT, {24'h0, mt[k]});
			wr(IDX_BAUD_EXP, {27'h0, et[k]});
			repeat (4) @(posedge mclk);
			n = 0;
			repeat (20) begin
				@(negedge mclk);
				n += baud_tick;
			end
			chk("ticks", nt[k], n);
		end
		close_out;
	end
endmodule
`default_nettype wire
